// [inc/smsc_consts.vh]
// Register indices, field positions, reset values and timing counts
`ifndef SMSC_CONSTS_VH
`define SMSC_CONSTS_VH
`define SMSC_IDX_W          15
`define SMSC_IDX_CR0        15'h4030
`define SMSC_IDX_CR1        15'h4031
`define SMSC_IDX_DIV        15'h4032
`define SMSC_IDX_DATA       15'h4033
`define SMSC_IDX_IRQEN      15'h4034
`define SMSC_CR0_RESET      8'h0b
`define SMSC_CR1_RESET      8'h02
`define SMSC_DIV_RESET      8'h00
`define SMSC_DATA_RESET     8'h00
`define SMSC_CR0_BUSY       7
`define SMSC_CR0_MS         6
`define SMSC_CR0_PHASE      5
`define SMSC_CR0_IDLEPOL    4
`define SMSC_CR0_SELECTED   3
`define SMSC_CR0_RAWSEL     2
`define SMSC_CR0_SHEMPTY    1
`define SMSC_CR0_RXMT       0
`define SMSC_CR1_DONE       7
`define SMSC_CR1_COLL       6
`define SMSC_CR1_FAULT      5
`define SMSC_CR1_OVR        4
`define SMSC_CR1_MODE_HI    3
`define SMSC_CR1_MODE_LO    2
`define SMSC_CR1_TXMT       1
`define SMSC_CR1_EN         0
`define SMSC_MODE_3WIRE     2'b00
`define SMSC_MODE_4WIRE_IN  2'b01
`define SMSC_FRAME_EDGES    4'hf
`define SMSC_NSS_FILT       2'h2
`endif

// [rtl/smsc_core.v]
// Byte-wide SPI master/slave controller with a classic Wishbone register slave
//
// How it works
// RL1: Master-select 1 makes SCLK here; 0 shifts only on the remote SCLK.
// RL2: Data write fills transmit buffer, clears empty flag; idle shifter takes it.
// RL3: Eight-bit frames MSB first; master drives shifter top bit, captures MISO.
// RL4: Frame end moves received byte to buffer unless slave overrun, sets done and transmit-empty.
// RL5: Transmit-empty sets when buffer moves to shifter, clears on new write.
// RL6: Write while transmit-empty is 0 sets collision flag, buffer unchanged.
// RL7: Slave shifter holds still without SCLK, shifts only on the shift edge of each SCLK cycle.
// RL8: Slave frame end clears receive-empty; data read sets it again.
// RL9: Slave frame end with unread buffer sets overrun, keeps old byte.
// RL10: Interrupt when enabled and any event flag set; flags clear by writing 0.
// RL11: Master with select mode 01 and raw NSS low: fault, drop master, disable.
// RL12: Select mode 00 ignores NSS; mode 01 uses NSS as an input.
// RL13: Select mode 1X drives NSS with the low select-mode bit.
// RL14: Remote master holds NSS low five clocks before clocking.
// RL15: Phase and polarity pick sample edge, shift edge and idle level.
// RL16: Phase and polarity change only while disabled, same at both ends; CR0 writes set them even while enabled.
// RL17: SCLK is clk over 2*(divider+1); divider writable only while disabled.
// RL18: Busy reads 1 while a frame is in progress.
// RL19: Slave-selected follows filtered NSS low; raw NSS level readable too.
// RL20: Master reads shifter-empty and receive-empty as 1; slave shows loading.
// RL21: MISO released when disabled or an unselected four-wire slave.
// RL22: NSS synchronised and filtered before it frames the slave.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "smsc_consts.vh"

module smsc_core #(
    parameter ADDR_W = 17
) (
    // Clock and reset
    input  wire              clk,
    input  wire              rst_b,
    // Wishbone slave
    input  wire              wbCyc,
    input  wire              wbStb,
    input  wire              wbWe,
    input  wire [ADDR_W-1:0] wbAdr,
    input  wire [3:0]        wbSel,
    input  wire [31:0]       wbDatIn,
    output reg  [31:0]       wbDatOut,
    output reg               wbAck,
    // Interrupt
    output wire              irq,
    // Serial clock pin
    input  wire              sclkIn,
    output reg               sclkOut,
    output wire              sclkOe,
    // Master-out pin
    input  wire              mosiIn,
    output wire              mosiOut,
    output wire              mosiOe,
    // Master-in pin
    input  wire              misoIn,
    output wire              misoOut,
    output wire              misoOe,
    // Select pin
    input  wire              raw_select_level_b,
    output wire              nssOut,
    output wire              nssOe
);

    // Control and status
    reg        masterSel;
    reg        clockPhase;
    reg        clockIdlePolarity;
    reg  [1:0] selectPinMode;
    reg        controllerEnable;
    reg        transferDoneFlag;
    reg        writeCollisionFlag;
    reg        modeFaultFlag;
    reg        receiveOverrunFlag;
    reg        transmitEmptyFlag;
    reg        rxEmpty;
    reg        txPending;
    reg        serialIrqEnable;
    reg  [7:0] divider;
    reg  [7:0] txBuf;
    reg  [7:0] rxBuf;
    // Shift engine
    reg  [7:0] shifter;
    reg        sampleBit;
    reg  [3:0] edgeCnt;
    reg  [7:0] divCnt;
    reg        busy;
    reg        shifterLoaded;
    reg        sclkPrev;
    // Select input conditioning
    reg        nssMeta;
    reg        rawSelectLevel;
    reg        nssFiltered;
    reg  [1:0] nssStable;

    wire [`SMSC_IDX_W-1:0] idx = wbAdr[ADDR_W-1:2];
    wire take = wbCyc & wbStb & ~wbAck;
    wire wrLane = take & wbWe & wbSel[0];
    wire rdData = take & ~wbWe & (idx == `SMSC_IDX_DATA);
    wire [7:0] wd = wbDatIn[7:0];

    // Write strobes, one per mapped index; unmapped writes fall through
    reg wrCr0;
    reg wrCr1;
    reg wrDiv;
    reg wrData;
    reg wrIrq;
    always @* begin
        wrCr0 = 1'b0;
        wrCr1 = 1'b0;
        wrDiv = 1'b0;
        wrData = 1'b0;
        wrIrq = 1'b0;
        if (wrLane) begin
            case (idx)
                `SMSC_IDX_CR0: wrCr0 = 1'b1;
                `SMSC_IDX_CR1: wrCr1 = 1'b1;
                `SMSC_IDX_DIV: wrDiv = 1'b1;
                `SMSC_IDX_DATA: wrData = 1'b1;
                `SMSC_IDX_IRQEN: wrIrq = 1'b1;
                default: wrCr0 = 1'b0;
            endcase
        end
    end

    wire slaveSelected = ~nssFiltered;
    wire selInput = (selectPinMode == `SMSC_MODE_4WIRE_IN);
    wire isMaster = controllerEnable & masterSel;
    wire slaveFramed = controllerEnable & ~masterSel & (~selInput | slaveSelected); // RL12 RL22
    // Only an enabled master can fault; a disabled one owns no bus
    wire modeFault = isMaster & selInput & ~rawSelectLevel; // RL11

    // Edge events for both roles
    wire masterEdge = isMaster & busy & (divCnt == divider); // RL17
    wire slaveEdge = slaveFramed & (sclkIn != sclkPrev); // RL7
    wire edgeEv = masterEdge | slaveEdge; // RL1
    wire edgeLead = isMaster ? (sclkOut == clockIdlePolarity)
                             : (sclkPrev == clockIdlePolarity);
    // Phase 0 samples on leading edge; phase 1 on trailing edge
    reg rxCap;
    reg txShift;
    always @* begin
        rxCap = 1'b0;
        txShift = 1'b0;
        case (clockPhase)
            1'b0: begin
                rxCap = edgeEv & edgeLead; // RL15
                txShift = edgeEv & ~edgeLead; // RL15
            end
            1'b1: begin
                rxCap = edgeEv & ~edgeLead; // RL15
                txShift = edgeEv & edgeLead & (edgeCnt != 4'h0); // RL15
            end
            default: begin
                rxCap = 1'b0;
                txShift = 1'b0;
            end
        endcase
    end
    wire lastEdge = edgeEv & (edgeCnt == `SMSC_FRAME_EDGES);
    wire inBit = isMaster ? misoIn : mosiIn; // RL3
    wire [7:0] rxByte = {shifter[6:0], clockPhase ? inBit : sampleBit};
    // Pending byte tracked apart from the flag, which frame end sets early
    wire masterStart = isMaster & ~busy & txPending & ~modeFault; // RL2
    wire slaveLoad = slaveFramed & ~busy & txPending
                     & ~shifterLoaded; // RL2
    wire rxFree = rxEmpty | rdData;

    assign mosiOut = shifter[7]; // RL3
    assign mosiOe = isMaster;
    assign sclkOe = isMaster; // RL1
    assign misoOut = shifter[7];
    assign misoOe = controllerEnable & ~masterSel & (~selInput | slaveSelected); // RL21
    assign nssOut = selectPinMode[0]; // RL13
    assign nssOe = selectPinMode[1]; // RL13
    wire anyEvent = transferDoneFlag | writeCollisionFlag | modeFaultFlag
                    | receiveOverrunFlag;
    assign irq = serialIrqEnable & anyEvent; // RL10

    // Two stages then a short steadiness filter
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nssMeta <= 1'b0;
            rawSelectLevel <= 1'b0;
            nssFiltered <= 1'b0;
            nssStable <= 2'h0;
        end else begin
            nssMeta <= raw_select_level_b;
            rawSelectLevel <= nssMeta;
            if (rawSelectLevel == nssFiltered) begin
                nssStable <= 2'h0;
            end else if (nssStable == `SMSC_NSS_FILT) begin
                nssFiltered <= rawSelectLevel; // RL22
                nssStable <= 2'h0;
            end else begin
                nssStable <= nssStable + 2'h1;
            end
        end
    end

    // Status bytes as software sees them
    wire [7:0] primaryStatus;
    wire [7:0] secondaryStatus;
    assign primaryStatus[`SMSC_CR0_BUSY]     = busy; // RL18
    assign primaryStatus[`SMSC_CR0_MS]       = masterSel;
    assign primaryStatus[`SMSC_CR0_PHASE]    = clockPhase;
    assign primaryStatus[`SMSC_CR0_IDLEPOL]  = clockIdlePolarity;
    assign primaryStatus[`SMSC_CR0_SELECTED] = slaveSelected; // RL19
    assign primaryStatus[`SMSC_CR0_RAWSEL]   = rawSelectLevel; // RL19
    assign primaryStatus[`SMSC_CR0_SHEMPTY]  = masterSel | ~(shifterLoaded | busy); // RL20
    assign primaryStatus[`SMSC_CR0_RXMT]     = masterSel | rxEmpty; // RL20
    assign secondaryStatus[`SMSC_CR1_DONE]    = transferDoneFlag;
    assign secondaryStatus[`SMSC_CR1_COLL]    = writeCollisionFlag;
    assign secondaryStatus[`SMSC_CR1_FAULT]   = modeFaultFlag;
    assign secondaryStatus[`SMSC_CR1_OVR]     = receiveOverrunFlag;
    assign secondaryStatus[`SMSC_CR1_MODE_HI] = selectPinMode[1];
    assign secondaryStatus[`SMSC_CR1_MODE_LO] = selectPinMode[0];
    assign secondaryStatus[`SMSC_CR1_TXMT]    = transmitEmptyFlag;
    assign secondaryStatus[`SMSC_CR1_EN]      = controllerEnable;

    // Read data chosen by index; unmapped indices read as zero
    reg [31:0] next_readData;
    always @* begin
        next_readData = 32'h0;
        case (idx)
            `SMSC_IDX_CR0: next_readData = {24'h0, primaryStatus};
            `SMSC_IDX_CR1: next_readData = {24'h0, secondaryStatus};
            `SMSC_IDX_DIV: next_readData = {24'h0, divider};
            `SMSC_IDX_DATA: next_readData = {24'h0, rxBuf}; // RL4
            `SMSC_IDX_IRQEN: next_readData = {31'h0, serialIrqEnable};
            default: next_readData = 32'h0;
        endcase
    end

    // Register bus answer: one wait state, unmapped reads as zero
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wbAck <= 1'b0;
            wbDatOut <= 32'h0;
        end else begin
            wbAck <= take;
            if (take & ~wbWe) begin
                wbDatOut <= next_readData;
            end
        end
    end

    // Configuration and software-visible flags
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            masterSel <= 1'b0;
            clockPhase <= 1'b0;
            clockIdlePolarity <= 1'b0;
            selectPinMode <= `SMSC_MODE_3WIRE;
            controllerEnable <= 1'b0;
            transferDoneFlag <= 1'b0;
            writeCollisionFlag <= 1'b0;
            modeFaultFlag <= 1'b0;
            receiveOverrunFlag <= 1'b0;
            transmitEmptyFlag <= 1'b1;
            rxEmpty <= 1'b1;
            txPending <= 1'b0;
            serialIrqEnable <= 1'b0;
            divider <= `SMSC_DIV_RESET;
            txBuf <= `SMSC_DATA_RESET;
            rxBuf <= `SMSC_DATA_RESET;
        end else begin
            // Software writes first so hardware sets below win
            if (wrCr0) begin
                masterSel <= wd[`SMSC_CR0_MS];
                clockPhase <= wd[`SMSC_CR0_PHASE];
                clockIdlePolarity <= wd[`SMSC_CR0_IDLEPOL];
            end
            if (wrCr1) begin
                if (!wd[`SMSC_CR1_DONE]) transferDoneFlag <= 1'b0; // RL10
                if (!wd[`SMSC_CR1_COLL]) writeCollisionFlag <= 1'b0; // RL10
                if (!wd[`SMSC_CR1_FAULT]) modeFaultFlag <= 1'b0; // RL10
                if (!wd[`SMSC_CR1_OVR]) receiveOverrunFlag <= 1'b0; // RL10
                selectPinMode <= wd[`SMSC_CR1_MODE_HI:`SMSC_CR1_MODE_LO];
                controllerEnable <= wd[`SMSC_CR1_EN];
            end
            if (wrDiv & ~controllerEnable) divider <= wd; // RL17
            if (wrIrq) serialIrqEnable <= wd[0];
            if (wrData) begin
                if (transmitEmptyFlag) begin
                    txBuf <= wd; // RL2
                    transmitEmptyFlag <= 1'b0; // RL5
                    txPending <= 1'b1; // RL2
                end else begin
                    writeCollisionFlag <= 1'b1; // RL6
                end
            end
            if (rdData) rxEmpty <= 1'b1; // RL8
            if (masterStart | slaveLoad) begin
                transmitEmptyFlag <= 1'b1; // RL5
                txPending <= 1'b0;
            end
            if (lastEdge) begin
                transferDoneFlag <= 1'b1; // RL4
                transmitEmptyFlag <= 1'b1; // RL4
                if (isMaster) begin
                    rxBuf <= rxByte; // RL4
                end else if (rxFree) begin
                    rxBuf <= rxByte; // RL4
                    rxEmpty <= 1'b0; // RL8
                end else begin
                    receiveOverrunFlag <= 1'b1; // RL9
                end
            end
            if (modeFault) begin
                modeFaultFlag <= 1'b1; // RL11
                masterSel <= 1'b0; // RL11
                controllerEnable <= 1'b0; // RL11
            end
        end
    end

    // Shift engine shared by both roles
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shifter <= 8'h00;
            sampleBit <= 1'b0;
            edgeCnt <= 4'h0;
            divCnt <= 8'h00;
            busy <= 1'b0;
            shifterLoaded <= 1'b0;
            sclkPrev <= 1'b0;
            sclkOut <= 1'b0;
        end else begin
            sclkPrev <= sclkIn;
            if (!controllerEnable | modeFault) begin
                // Abandon any frame and park the clock at idle
                busy <= 1'b0;
                edgeCnt <= 4'h0;
                divCnt <= 8'h00;
                shifterLoaded <= 1'b0;
                sclkOut <= clockIdlePolarity; // RL15
            end else if (!masterSel & ~slaveFramed) begin
                // Deselected slave restarts its frame count
                busy <= 1'b0;
                edgeCnt <= 4'h0;
                sclkOut <= clockIdlePolarity;
            end else begin
                if (masterStart) begin
                    shifter <= txBuf; // RL2
                    busy <= 1'b1; // RL18
                    divCnt <= 8'h00;
                end
                if (slaveLoad) begin
                    shifter <= txBuf; // RL2
                    shifterLoaded <= 1'b1; // RL20
                end
                if (!busy) sclkOut <= clockIdlePolarity;
                if (isMaster & busy) begin
                    if (masterEdge) begin
                        divCnt <= 8'h00;
                        sclkOut <= ~sclkOut; // RL17
                    end else begin
                        divCnt <= divCnt + 8'h01;
                    end
                end
                if (slaveEdge) begin
                    busy <= 1'b1; // RL18
                    shifterLoaded <= 1'b1; // RL20
                end
                if (rxCap) sampleBit <= inBit; // RL3
                if (txShift) shifter <= {shifter[6:0], sampleBit}; // RL3
                if (edgeEv) edgeCnt <= edgeCnt + 4'h1;
                if (lastEdge) begin
                    shifter <= rxByte;
                    busy <= 1'b0; // RL18
                    edgeCnt <= 4'h0;
                    shifterLoaded <= 1'b0;
                end
            end
        end
    end

endmodule // smsc_core

// [tb/smsc_monitor.sv]
// Checker of bus handshake, pin roles, read data and interrupt clearing
`timescale 1ns/1ps
`include "smsc_consts.vh"
module smsc_monitor #(
    parameter ADDR_W = 17
) (
    // Clock and reset
    input wire              clk,
    input wire              rst_b,
    // Register bus
    input wire              wbCyc,
    input wire              wbStb,
    input wire              wbWe,
    input wire [ADDR_W-1:0] wbAdr,
    input wire [31:0]       wbDatOut,
    input wire              wbAck,
    // Interrupt and pin enables
    input wire              irq,
    input wire              sclkOe,
    input wire              mosiOe,
    input wire              misoOe
);
    wire              req = wbCyc && wbStb && !wbAck;
    wire [ADDR_W-3:0] idx = wbAdr[ADDR_W-1:2];
    wire              gap = idx < `SMSC_IDX_CR0 || idx > `SMSC_IDX_IRQEN;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_ackOne; wbAck |=> !wbAck; endproperty
    a_ackOne: assert property (p_ackOne) else $error("ack longer than one cycle");
    property p_ackNext; req |=> wbAck; endproperty
    a_ackNext: assert property (p_ackNext) else $error("ack missing after request");
    property p_ackCause; $rose(wbAck) |-> $past(req); endproperty
    a_ackCause: assert property (p_ackCause) else $error("ack without request");
    property p_gapZero; req && !wbWe && gap |=> wbDatOut == 32'h0; endproperty
    a_gapZero: assert property (p_gapZero) else $error("unmapped read not zero");
    property p_upper; wbAck |-> wbDatOut[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("read data upper bits set");
    property p_master; sclkOe |-> mosiOe && !misoOe; endproperty
    a_master: assert property (p_master) else $error("master pin roles wrong");
    property p_slave; misoOe |-> !sclkOe && !mosiOe; endproperty
    a_slave: assert property (p_slave) else $error("slave drives master pins");
    property p_irqClr; $fell(irq) |-> $past(wbCyc && wbStb && wbWe); endproperty
    a_irqClr: assert property (p_irqClr) else $error("irq fell without write");
endmodule // smsc_monitor

bind smsc_core smsc_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .clk(clk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbDatOut(wbDatOut), .wbAck(wbAck), .irq(irq),
    .sclkOe(sclkOe), .mosiOe(mosiOe), .misoOe(misoOe));

// [tb/smsc_remote.sv]
// Remote mode 00 slave that echoes each received byte in the next frame
`timescale 1ns/1ps
module smsc_remote #(
    parameter [7:0] FIRST = 8'h3c
) (
    // Link in
    input  wire       clk,
    input  wire       sclk,
    input  wire       sclkOe,
    input  wire       mosi,
    // Link out
    output wire       miso,
    output reg  [7:0] shifter,
    output reg  [7:0] frames
);
    reg       last = 1'b0;
    reg       sampled = 1'b0;
    reg [2:0] bitCnt = 3'h0;
    // Released line shows the inverse, so a stale bit never passes
    assign miso = sclkOe ? shifter[7] : ~shifter[7];
    initial begin
        shifter = FIRST;
        frames = 8'h0;
    end
    always @(posedge clk) begin
        last <= sclk;
        if (sclkOe && sclk && !last) begin
            sampled <= mosi;
        end
        if (sclkOe && !sclk && last) begin
            shifter <= {shifter[6:0], sampled};
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
                frames <= frames + 8'h1;
            end
        end
    end
endmodule // smsc_remote

// [tb/tb_spi_master_slave_controller.sv]
// Self-checking bench: registers, master and slave transfers, faults
`timescale 1ns/1ps
`include "smsc_consts.vh"
module tb_spi_master_slave_controller;
    reg         clk = 1'b0;
    reg         rst_b = 1'b0;
    reg         wbCyc = 1'b0;
    reg         wbStb = 1'b0;
    reg         wbWe = 1'b0;
    reg  [16:0] wbAdr = 17'h0;
    reg  [3:0]  wbSel = 4'h0;
    reg  [31:0] wbDatIn = 32'h0;
    reg         sclkDrv = 1'b0;
    reg         mosiDrv = 1'b0;
    reg         nssDrv_b = 1'b0;
    wire [31:0] wbDatOut;
    wire        wbAck, irq, sclkOut, sclkOe, mosiOut, mosiOe, misoRem;
    wire        misoOut, misoOe, nssOut, nssOe;
    wire [7:0]  remData, remFrames;
    wire        sclkPin = sclkOe ? sclkOut : sclkDrv;
    wire        mosiPin = mosiOe ? mosiOut : mosiDrv;
    wire        misoPin = misoOe ? misoOut : misoRem;
    wire        nssPin_b = nssOe ? nssOut : nssDrv_b;
    reg  [31:0] rd;
    reg  [7:0]  rx;
    integer     num_errors = 0;
    integer     total_checks = 0;
    integer     i;
    always #5 clk = ~clk;
    smsc_core #(.ADDR_W(17)) dut (
        .clk(clk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .irq(irq),
        .sclkIn(sclkPin), .sclkOut(sclkOut), .sclkOe(sclkOe), .mosiIn(mosiPin),
        .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoPin), .misoOut(misoOut),
        .misoOe(misoOe), .raw_select_level_b(nssPin_b), .nssOut(nssOut), .nssOe(nssOe));
    smsc_remote remote (.clk(clk), .sclk(sclkPin), .sclkOe(sclkOe), .mosi(mosiPin),
        .miso(misoRem), .shifter(remData), .frames(remFrames));
    task complete_run;
        begin
            $display("checks %0d errors %0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    task check(input string what, input [31:0] exp, input [31:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("ERROR %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task bus(input we, input [14:0] idx, input [7:0] dat);
        integer n;
        begin
            @(posedge clk);
            wbCyc <= 1'b1;
            wbStb <= 1'b1;
            wbWe <= we;
            wbAdr <= {idx, 2'b00};
            wbSel <= 4'h1;
            wbDatIn <= {24'h0, dat};
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (wbAck !== 1'b1 && n < 20);
            rd = wbDatOut;
            wbCyc <= 1'b0;
            wbStb <= 1'b0;
            check("bus ack", 32'h1, {31'h0, wbAck});
            if (wbAck !== 1'b1) complete_run;
        end
    endtask
    task rdChk(input [14:0] idx, input [7:0] exp, input string what);
        begin
            bus(1'b0, idx, 8'h00);
            check(what, {24'h0, exp}, rd);
        end
    endtask
    // Remote master in mode 00, slow enough for the select filter
    task slaveByte(input [7:0] tx, output [7:0] got);
        integer b;
        begin
            for (b = 7; b >= 0; b = b - 1) begin
                mosiDrv <= tx[b];
                repeat (4) @(posedge clk);
                got[b] = misoPin;
                sclkDrv <= 1'b1;
                repeat (4) @(posedge clk);
                sclkDrv <= 1'b0;
            end
            repeat (4) @(posedge clk);
            mosiDrv <= ~tx[0];
        end
    endtask
    task scnReset;
        begin
            rdChk(`SMSC_IDX_CR0, 8'h0b, "cr0 reset");
            rdChk(`SMSC_IDX_CR1, 8'h02, "cr1 reset");
            rdChk(`SMSC_IDX_DIV, 8'h00, "div reset");
            rdChk(`SMSC_IDX_DATA, 8'h00, "data reset");
            rdChk(15'h4035, 8'h00, "unmapped");
        end
    endtask
    task scnMaster;
        begin
            bus(1'b1, `SMSC_IDX_DIV, 8'h01);
            bus(1'b1, `SMSC_IDX_IRQEN, 8'h01);
            for (i = 3; i >= 0; i = i - 1) begin
                bus(1'b1, `SMSC_IDX_CR1, 8'h08);
                bus(1'b1, `SMSC_IDX_CR0, {2'b01, i[1], i[0], 4'h0});
                bus(1'b1, `SMSC_IDX_CR1, 8'h09);
                check("sclk idle", {31'h0, i[0]}, {31'h0, sclkOut});
            end
            check("nss pin", 32'h2, {30'h0, nssOe, nssOut});
            bus(1'b1, `SMSC_IDX_DIV, 8'h07);
            rdChk(`SMSC_IDX_DIV, 8'h01, "div locked");
            bus(1'b1, `SMSC_IDX_DATA, 8'ha5);
            bus(1'b1, `SMSC_IDX_DATA, 8'h5a);
            bus(1'b1, `SMSC_IDX_DATA, 8'h11);
            i = 0;
            while (remFrames !== 8'h2 && i < 500) begin
                @(posedge clk);
                i = i + 1;
            end
            check("frames", 32'h2, {24'h0, remFrames});
            if (remFrames !== 8'h2) complete_run;
            check("remote rx", 32'h5a, {24'h0, remData});
            rdChk(`SMSC_IDX_DATA, 8'ha5, "master rx");
            rdChk(`SMSC_IDX_CR1, 8'hcb, "cr1 flags");
            check("irq set", 32'h1, {31'h0, irq});
            rdChk(`SMSC_IDX_CR0, 8'h4b, "cr0 master");
            bus(1'b1, `SMSC_IDX_CR1, 8'h09);
            check("irq clear", 32'h0, {31'h0, irq});
        end
    endtask
    task scnSlave;
        begin
            nssDrv_b <= 1'b1;
            bus(1'b1, `SMSC_IDX_CR1, 8'h04);
            bus(1'b1, `SMSC_IDX_CR0, 8'h00);
            bus(1'b1, `SMSC_IDX_CR1, 8'h05);
            nssDrv_b <= 1'b0;
            repeat (10) @(posedge clk);
            check("miso on", 32'h1, {31'h0, misoOe});
            bus(1'b1, `SMSC_IDX_DATA, 8'h96);
            slaveByte(8'h81, rx);
            check("slave tx", 32'h96, {24'h0, rx});
            bus(1'b0, `SMSC_IDX_CR0, 8'h00);
            check("unread sel", 32'h2, {30'h0, rd[3], rd[0]});
            slaveByte(8'h42, rx);
            rdChk(`SMSC_IDX_CR1, 8'h97, "overrun");
            rdChk(`SMSC_IDX_DATA, 8'h81, "kept byte");
            bus(1'b0, `SMSC_IDX_CR0, 8'h00);
            check("rx empty", 32'h1, {31'h0, rd[0]});
            nssDrv_b <= 1'b1;
            repeat (8) @(posedge clk);
            check("miso off", 32'h0, {31'h0, misoOe});
        end
    endtask
    task scnFault;
        begin
            bus(1'b1, `SMSC_IDX_CR1, 8'h04);
            bus(1'b1, `SMSC_IDX_CR0, 8'h40);
            bus(1'b1, `SMSC_IDX_CR1, 8'h05);
            rdChk(`SMSC_IDX_CR1, 8'h07, "no fault");
            nssDrv_b <= 1'b0;
            repeat (8) @(posedge clk);
            rdChk(`SMSC_IDX_CR1, 8'h26, "fault");
            bus(1'b0, `SMSC_IDX_CR0, 8'h00);
            check("master off", 32'h0, {31'h0, rd[6]});
            check("irq fault", 32'h1, {31'h0, irq});
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        scnReset;
        scnMaster;
        scnSlave;
        scnFault;
        complete_run;
    end
endmodule // tb_spi_master_slave_controller
